// ===== src/dtsr_top.sv
// Purpose: timing signal routing for scan gating, waveform update and counter 0
// Assumes: classic Wishbone slave, one 250 MHz clock, asynchronous pins
// Notes: every access is acked one cycle after it is presented
`timescale 1ns/1ns
module dtsr_top
   import dtsr_pkg::*;
#(
   parameter int NPIN = DTSR_NPIN,
   parameter int CW = DTSR_CW
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NPIN-1:0] pfi_i,
   output logic [NPIN-1:0] pfi_o,
   output logic [NPIN-1:0] pfi_oe_o,
   input wire logic digital_line_6_i,
   input wire logic buf_done_i,
   output logic scan_start_o,
   output logic dac_update_o,
   output logic wave_active_o,
   output logic counter0_output_o,
   output logic counter0_output_oe_o
);
   typedef struct packed
   {
      logic ack;
      logic [31:0] rdat;
      logic [31:0] acq_cfg;
      logic [31:0] scan_div;
      logic [31:0] wave_cfg;
      logic [31:0] ui_div;
      logic [31:0] ctr_cfg;
      logic [31:0] ctr_load;
      logic [31:0] pin_oe;
      logic [NPIN-1:0] sy1;
      logic [NPIN-1:0] sy2;
      logic d6a;
      logic d6b;
      logic [31:0] fast_acc;
      logic [31:0] slow_acc;
      logic [CW-1:0] scan_cnt;
      logic gate_blk;
      logic scan_allow;
      logic scan_start;
      logic wave_run;
      logic ui_run;
      logic [CW-1:0] ui_cnt;
      logic [7:0] trig_cnt;
      logic [7:0] upd_cnt;
      logic dac_upd;
      logic cclk_sq;
      logic cgate_open;
      logic [CW-1:0] ctr;
      logic [CW-1:0] ctr_save;
      logic tc_pulse;
      logic tc_tgl;
      logic cout;
      logic [NPIN-1:0] pins;
   } dtsr_state_s;

   dtsr_state_s s_q;
   dtsr_state_s s_d;

   logic gate_lvl, gate_edge, si_lvl, si_edge, trig_lvl, trig_edge;
   logic upd_lvl, upd_edge, ui_lvl, ui_edge, cclk_lvl, cclk_edge, cgate_lvl, cgate_edge;
   logic fast_tick, slow_tick, si_tick, ui_tick, cclk_tick;
   logic gate_act, scan_req, int_upd, upd_req, upd_fire, ctr_up, ctr_run, tc;
   logic acc_ok, wr;
   logic [32:0] fast_nx, slow_nx;

   // Fractional accumulator: carry is one timebase tick
   function automatic logic [32:0] acc_step(input logic [31:0] acc, input logic [31:0] inc);
      logic [31:0] sum;
      sum = acc + inc;
      if (sum >= CLK_HZ)
      begin
         acc_step = {1'b1, sum - CLK_HZ};
      end
      else
      begin
         acc_step = {1'b0, sum};
      end
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] be, input logic [31:0] m);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (be[i])
         begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      merge = r & m;
   endfunction

   function automatic logic [31:0] zext(input logic [CW-1:0] v);
      zext = 32'(v);
   endfunction

   dtsr_pin_sel #(.NPIN(NPIN)) u_gate (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.acq_cfg[F_GATE_PIN +: 4]), .inv_i(s_q.acq_cfg[F_GATE_INV]),
      .level_o(gate_lvl), .edge_o(gate_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_si (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.acq_cfg[F_SI_PIN +: 4]), .inv_i(s_q.acq_cfg[F_SI_INV]),
      .level_o(si_lvl), .edge_o(si_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_trig (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.wave_cfg[F_TRIG_PIN +: 4]), .inv_i(s_q.wave_cfg[F_TRIG_FALL]),
      .level_o(trig_lvl), .edge_o(trig_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_upd (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.wave_cfg[F_UPD_PIN +: 4]), .inv_i(s_q.wave_cfg[F_UPD_FALL]),
      .level_o(upd_lvl), .edge_o(upd_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_ui (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.wave_cfg[F_UI_PIN +: 4]), .inv_i(s_q.wave_cfg[F_UI_INV]),
      .level_o(ui_lvl), .edge_o(ui_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_cclk (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.ctr_cfg[F_CCLK_PIN +: 4]), .inv_i(s_q.ctr_cfg[F_CCLK_FALL]),
      .level_o(cclk_lvl), .edge_o(cclk_edge));
   dtsr_pin_sel #(.NPIN(NPIN)) u_cgate (
      .clk_i(clk_i), .rst_i(rst_i), .pins_i(s_q.sy2),
      .sel_i(s_q.ctr_cfg[F_CGATE_PIN +: 4]), .inv_i(s_q.ctr_cfg[F_CGATE_FALL]),
      .level_o(cgate_lvl), .edge_o(cgate_edge));

   always_comb
   begin
      s_d = s_q;
      s_d.sy1 = pfi_i;
      s_d.sy2 = s_q.sy1;
      s_d.d6a = digital_line_6_i;
      s_d.d6b = s_q.d6a;
      fast_nx = acc_step(s_q.fast_acc, TB_FAST_HZ);
      slow_nx = acc_step(s_q.slow_acc, TB_SLOW_HZ);
      s_d.fast_acc = fast_nx[31:0];
      s_d.slow_acc = slow_nx[31:0];
      fast_tick = fast_nx[32];
      slow_tick = slow_nx[32];
      // Level-detected clock sources count their active-going transitions
      si_tick = s_q.acq_cfg[F_SI_EXT] ? si_edge : (s_q.acq_cfg[F_SI_SLOW] ? slow_tick : fast_tick);
      ui_tick = s_q.wave_cfg[F_UI_EXT] ? ui_edge : (s_q.wave_cfg[F_UI_SLOW] ? slow_tick : fast_tick);
      cclk_tick = s_q.ctr_cfg[F_CCLK_EXT] ? cclk_edge : (s_q.ctr_cfg[F_CCLK_SLOW] ? slow_tick : fast_tick);

      // Scan interval counter and acquisition gate
      scan_req = 1'b0;
      if (s_q.acq_cfg[F_ACQ_RUN] && si_tick)
      begin
         if (s_q.scan_cnt == '0)
         begin
            scan_req = 1'b1;
            s_d.scan_cnt = s_q.scan_div[CW-1:0];
         end
         else
         begin
            s_d.scan_cnt = s_q.scan_cnt - 1'b1;
         end
      end
      if (s_q.acq_cfg[F_GATE_EN] && s_q.acq_cfg[F_GATE_EDGE] && gate_edge)
      begin
         s_d.gate_blk = ~s_q.gate_blk;
      end
      gate_act = s_q.acq_cfg[F_GATE_EN] & (s_q.acq_cfg[F_GATE_EDGE] ? s_q.gate_blk : gate_lvl);
      s_d.scan_start = 1'b0;
      if (scan_req)
      begin
         s_d.scan_allow = ~gate_act;
         s_d.scan_start = ~gate_act;
      end

      // Waveform trigger and update interval counter
      if (s_q.trig_cnt != 8'h00)
      begin
         s_d.trig_cnt = s_q.trig_cnt - 8'h01;
      end
      if (trig_edge)
      begin
         s_d.wave_run = 1'b1;
         s_d.trig_cnt = 8'(TRIG_PW_CYC);
         if (!s_q.wave_cfg[F_UPD_EXT])
         begin
            s_d.ui_run = 1'b1;
            s_d.ui_cnt = s_q.ui_div[CW-1:0];
         end
      end
      int_upd = 1'b0;
      if (s_q.ui_run && ui_tick && !trig_edge)
      begin
         if (s_q.ui_cnt == '0)
         begin
            int_upd = 1'b1;
            s_d.ui_cnt = s_q.ui_div[CW-1:0];
         end
         else
         begin
            s_d.ui_cnt = s_q.ui_cnt - 1'b1;
         end
      end
      upd_req = s_q.wave_cfg[F_UPD_EXT] ? upd_edge : int_upd;
      upd_fire = upd_req & s_q.wave_cfg[F_POSTED] & ~s_q.wave_cfg[F_SW_GATE];
      s_d.dac_upd = upd_fire;
      if (upd_fire)
      begin
         s_d.upd_cnt = 8'(UPD_PW_CYC);
      end
      else if (s_q.upd_cnt != 8'h00)
      begin
         s_d.upd_cnt = s_q.upd_cnt - 8'h01;
      end

      // Counter 0
      if (fast_tick || slow_tick)
      begin
         s_d.cclk_sq = s_q.cclk_sq ^ (s_q.ctr_cfg[F_CCLK_SLOW] ? slow_tick : fast_tick);
      end
      if (cgate_edge)
      begin
         s_d.cgate_open = ~s_q.cgate_open;
         if (s_q.ctr_cfg[F_CGATE_SAVE])
         begin
            s_d.ctr_save = s_q.ctr;
         end
      end
      ctr_up = s_q.ctr_cfg[F_DIR_PIN] ? s_q.d6b : s_q.ctr_cfg[F_DIR_UP];
      ctr_run = s_q.ctr_cfg[F_CTR_EN] & (~s_q.ctr_cfg[F_CGATE_RUN] | s_q.cgate_open);
      tc = 1'b0;
      if (ctr_run && cclk_tick)
      begin
         if (ctr_up)
         begin
            tc = (s_q.ctr == s_q.ctr_load[CW-1:0]);
            s_d.ctr = tc ? '0 : s_q.ctr + 1'b1;
         end
         else
         begin
            tc = (s_q.ctr == '0);
            s_d.ctr = tc ? s_q.ctr_load[CW-1:0] : s_q.ctr - 1'b1;
         end
      end
      s_d.tc_pulse = tc;
      if (tc)
      begin
         s_d.tc_tgl = ~s_q.tc_tgl;
      end
      s_d.cout = (s_q.ctr_cfg[F_OUT_TGL] ? s_d.tc_tgl : s_d.tc_pulse) ^ s_q.ctr_cfg[F_OUT_INV];

      // Echo pins, registered
      s_d.pins = '0;
      s_d.pins[PIN_UPD] = (s_d.upd_cnt == 8'h00);
      s_d.pins[PIN_TRIG] = (s_d.trig_cnt != 8'h00);
      s_d.pins[PIN_CCLK] = s_q.ctr_cfg[F_CCLK_EXT] ? cclk_lvl : s_q.cclk_sq;
      s_d.pins[PIN_CGATE] = cgate_lvl;

      // Wishbone slave
      acc_ok = wb_cyc_i & wb_stb_i & ~s_q.ack;
      wr = acc_ok & wb_we_i;
      s_d.ack = acc_ok;
      if (wr)
      begin
         case (wb_adr_i)
            A_ACQ_CFG: s_d.acq_cfg = merge(s_q.acq_cfg, wb_dat_i, wb_sel_i, M_ACQ);
            A_SCAN_DIV: s_d.scan_div = merge(s_q.scan_div, wb_dat_i, wb_sel_i, M_DIV);
            A_WAVE_CFG: s_d.wave_cfg = merge(s_q.wave_cfg, wb_dat_i, wb_sel_i, M_WAVE);
            A_UI_DIV: s_d.ui_div = merge(s_q.ui_div, wb_dat_i, wb_sel_i, M_DIV);
            A_CTR_CFG: s_d.ctr_cfg = merge(s_q.ctr_cfg, wb_dat_i, wb_sel_i, M_CTR);
            A_CTR_LOAD:
            begin
               s_d.ctr_load = merge(s_q.ctr_load, wb_dat_i, wb_sel_i, M_DIV);
               s_d.ctr = s_d.ctr_load[CW-1:0];
            end
            A_PIN_OE: s_d.pin_oe = merge(s_q.pin_oe, wb_dat_i, wb_sel_i, M_OE);
            default: ;
         endcase
      end
      // A trigger in the same cycle as a stop wins
      if (((wr && wb_adr_i == A_CMD && wb_sel_i[0] && wb_dat_i[F_CMD_UI_STOP]) || buf_done_i) && !trig_edge)
      begin
         s_d.ui_run = 1'b0;
         s_d.wave_run = 1'b0;
      end
      if (acc_ok && !wb_we_i)
      begin
         case (wb_adr_i)
            A_ACQ_CFG: s_d.rdat = s_q.acq_cfg;
            A_SCAN_DIV: s_d.rdat = s_q.scan_div;
            A_WAVE_CFG: s_d.rdat = s_q.wave_cfg;
            A_UI_DIV: s_d.rdat = s_q.ui_div;
            A_CTR_CFG: s_d.rdat = s_q.ctr_cfg;
            A_CTR_LOAD: s_d.rdat = s_q.ctr_load;
            A_PIN_OE: s_d.rdat = s_q.pin_oe;
            A_STATUS: s_d.rdat = {26'h0, s_q.cout, ctr_run, s_q.gate_blk, s_q.ui_run, s_q.wave_run,
                                  s_q.scan_allow};
            A_CTR_SAVE: s_d.rdat = (zext(s_q.ctr) << 16) | zext(s_q.ctr_save);
            default: s_d.rdat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign pfi_o = s_q.pins;
   assign pfi_oe_o = s_q.pin_oe[NPIN-1:0];
   assign scan_start_o = s_q.scan_start;
   assign dac_update_o = s_q.dac_upd;
   assign wave_active_o = s_q.wave_run;
   assign counter0_output_o = s_q.cout;
   assign counter0_output_oe_o = s_q.pin_oe[OE_COUT];

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_trig_hi;
      pfi_o[PIN_TRIG] [*8];
   endsequence
   sequence s_upd_lo;
      !pfi_o[PIN_UPD] [*8];
   endsequence

   property p_gate_level;
      scan_req && s_q.acq_cfg[F_GATE_EN] && !s_q.acq_cfg[F_GATE_EDGE] && gate_lvl |=> !scan_start_o;
   endproperty
   a_gate_level: assert property (p_gate_level) else $error("scan started while level gate active");

   property p_gate_toggle;
      s_q.acq_cfg[F_GATE_EN] && s_q.acq_cfg[F_GATE_EDGE] && gate_edge |=> s_q.gate_blk != $past(s_q.gate_blk);
   endproperty
   a_gate_toggle: assert property (p_gate_toggle) else $error("edge gate did not alternate");

   property p_gate_hold;
      !scan_req |=> $stable(s_q.scan_allow);
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("gate state changed mid scan");

   property p_trig_pulse;
      trig_edge |=> s_trig_hi ##1 pfi_o[PIN_TRIG] [*5] ##1 !pfi_o[PIN_TRIG];
   endproperty
   a_trig_pulse: assert property (p_trig_pulse) else $error("trigger echo width wrong");

   property p_upd_pulse;
      upd_fire |=> s_upd_lo ##[60:70] pfi_o[PIN_UPD];
   endproperty
   a_upd_pulse: assert property (p_upd_pulse) else $error("update echo width wrong");

   property p_dac_fast;
      s_q.wave_cfg[F_UPD_EXT] && upd_edge && s_q.wave_cfg[F_POSTED] && !s_q.wave_cfg[F_SW_GATE]
         |-> ##[1:25] dac_update_o;
   endproperty
   a_dac_fast: assert property (p_dac_fast) else $error("DAC update late");

   property p_sw_gate;
      s_q.wave_cfg[F_SW_GATE] && $past(s_q.wave_cfg[F_SW_GATE]) |-> !dac_update_o;
   endproperty
   a_sw_gate: assert property (p_sw_gate) else $error("update passed software gate");

   property p_ui_start;
      trig_edge && !s_q.wave_cfg[F_UPD_EXT] |=> s_q.ui_run && wave_active_o;
   endproperty
   a_ui_start: assert property (p_ui_start) else $error("trigger did not start update counter");

   property p_oe_reset;
      $past(rst_i) |-> pfi_oe_o == '0 && !counter0_output_oe_o;
   endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("echo pin driven after reset");
endmodule

// ===== src/dtsr_pkg.sv
// Purpose: constants for the acquisition timing signal routing block
// Assumes: 250 MHz system clock, classic Wishbone register access
// Notes: all registers reset to zero
// Functional notes
// - Any function pin may be the acquisition gate, level or edge, either polarity.
// - Level-mode gate asserted masks scan starts.
// - Edge-mode gate: first active edge disables scans, next re-enables, alternating.
// - Gate changes apply only at the next scan start.
// - Scan interval clock drives the scan counter; external source is level detected.
// - Without external source, scan interval clock is the 20 MHz or 100 kHz timebase.
// - Waveform trigger edge starts generation and the update interval counter.
// - Waveform trigger pin echoes the actual trigger, high pulse 50 to 100 ns.
// - Selected update strobe edge updates the DACs, only in posted-update mode.
// - Update strobe pin echoes the applied update, low pulse 300 to 350 ns.
// - DACs update within 100 ns; source spaces strobes for latch writes.
// - Update interval counter makes strobes; trigger starts, software or buffer stops.
// - Software gate suppresses all DAC updates.
// - Update interval clock: external level detected, else 20 MHz or 100 kHz.
// - Counter 0 clock: selectable pin and edge or timebase; echoed on its pin.
// - Counter 0 gate: selectable pin and edge; starts, stops, saves count; echoed.
// - Counter 0 output pulses or toggles on terminal count, polarity selectable.
// - Direction from digital line 6 when enabled, else from software.
// - Echo pins start as high-impedance inputs until enabled.
package dtsr_pkg;
   localparam int DTSR_NPIN = 10;
   localparam int DTSR_CW = 16;
   localparam logic [31:0] DTSR_RST = 32'h0000_0000;
   localparam logic [7:0] A_ACQ_CFG = 8'h00;
   localparam logic [7:0] A_SCAN_DIV = 8'h04;
   localparam logic [7:0] A_WAVE_CFG = 8'h08;
   localparam logic [7:0] A_UI_DIV = 8'h0c;
   localparam logic [7:0] A_CTR_CFG = 8'h10;
   localparam logic [7:0] A_CTR_LOAD = 8'h14;
   localparam logic [7:0] A_CMD = 8'h18;
   localparam logic [7:0] A_PIN_OE = 8'h1c;
   localparam logic [7:0] A_STATUS = 8'h20;
   localparam logic [7:0] A_CTR_SAVE = 8'h24;
   localparam logic [31:0] M_ACQ = 32'h0000_7fff;
   localparam logic [31:0] M_DIV = 32'h0000_ffff;
   localparam logic [31:0] M_WAVE = 32'h037f_3f1f;
   localparam logic [31:0] M_CTR = 32'h000f_ff7f;
   localparam logic [31:0] M_OE = 32'h0000_0760;
   localparam int F_GATE_PIN = 0, F_GATE_INV = 4, F_GATE_EDGE = 5, F_GATE_EN = 6, F_ACQ_RUN = 7;
   localparam int F_SI_PIN = 8, F_SI_INV = 12, F_SI_EXT = 13, F_SI_SLOW = 14;
   localparam int F_TRIG_PIN = 0, F_TRIG_FALL = 4, F_UPD_PIN = 8, F_UPD_FALL = 12, F_UPD_EXT = 13;
   localparam int F_UI_PIN = 16, F_UI_INV = 20, F_UI_EXT = 21, F_UI_SLOW = 22;
   localparam int F_POSTED = 24, F_SW_GATE = 25;
   localparam int F_CCLK_PIN = 0, F_CCLK_FALL = 4, F_CCLK_EXT = 5, F_CCLK_SLOW = 6;
   localparam int F_CGATE_PIN = 8, F_CGATE_FALL = 12, F_CGATE_RUN = 13, F_CGATE_SAVE = 14;
   localparam int F_CTR_EN = 15, F_OUT_TGL = 16, F_OUT_INV = 17, F_DIR_PIN = 18, F_DIR_UP = 19;
   localparam int F_CMD_UI_STOP = 0;
   localparam int PIN_UPD = 5, PIN_TRIG = 6, PIN_CCLK = 8, PIN_CGATE = 9, OE_COUT = 10;
   localparam int CLK_PERIOD_NS = 4;
   localparam logic [31:0] CLK_HZ = 32'd250_000_000;
   localparam logic [31:0] TB_FAST_HZ = 32'd20_000_000;
   localparam logic [31:0] TB_SLOW_HZ = 32'd100_000;
   localparam int TRIG_PW_MIN_NS = 50;
   localparam int TRIG_PW_MAX_NS = 100;
   localparam int UPD_PW_MIN_NS = 300;
   localparam int UPD_PW_MAX_NS = 350;
   localparam int DAC_LAT_MAX_NS = 100;
   localparam int TRIG_PW_CYC = (TRIG_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int UPD_PW_CYC = (UPD_PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DAC_LAT_CYC = DAC_LAT_MAX_NS / CLK_PERIOD_NS;
endpackage

// ===== src/dtsr_pin_sel.sv
// Purpose: pick one synchronised function pin, apply polarity, find active edges
// Assumes: pins_i already passed two flip-flops
// Notes: edge_o is a one-cycle strobe on the active-going transition
`timescale 1ns/1ns
module dtsr_pin_sel
   import dtsr_pkg::*;
#(
   parameter int NPIN = DTSR_NPIN
)(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NPIN-1:0] pins_i,
   input wire logic [3:0] sel_i,
   input wire logic inv_i,
   output logic level_o,
   output logic edge_o
);
   typedef struct packed
   {
      logic prev;
   } dtsr_sel_s;

   dtsr_sel_s s_q;
   dtsr_sel_s s_d;
   logic lvl;

   always_comb
   begin
      lvl = 1'b0;
      if (int'(sel_i) < NPIN)
      begin
         lvl = pins_i[sel_i] ^ inv_i;
      end
      s_d.prev = lvl;
      level_o = lvl;
      edge_o = lvl & ~s_q.prev;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

// ===== bench/dtsr_pin_drv.sv
// Purpose: external instrument model driving the function pins and direction line
// Assumes: lines change by non-blocking assignment just after a rising edge
// Notes: lines are always driven, never left floating
`timescale 1ns/1ns
module dtsr_pin_drv (
   input wire logic clk_i,
   output logic [9:0] pin_o,
   output logic dir_o
);
   initial
   begin
      pin_o = 10'h000;
      dir_o = 1'b0;
   end
   task automatic set_pin(input int p, input logic v);
      @(posedge clk_i);
      pin_o[p] <= v;
   endtask
   // Idle gap keeps strobes far apart so each one completes
   task automatic pulse(input int p, input int w);
      set_pin(p, 1'b1);
      repeat (w) @(posedge clk_i);
      pin_o[p] <= 1'b0;
      repeat (100) @(posedge clk_i);
   endtask
endmodule

// ===== bench/tb_dtsr_top.sv
// Purpose: self-checking bench for the timing signal routing block
// Assumes: Wishbone ack one cycle after a request is taken
// Notes: expected counts follow from divider values and timebase rates
`timescale 1ns/1ns
module tb_dtsr_top
   import dtsr_pkg::*;
   ;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, buf_done = 1'b0, wb_ack;
   logic [7:0] wb_adr = 8'h00;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
   logic [9:0] pin_lvl, echo, oe;
   logic dir_lvl, scan_start, dac_update, wave_active, c0_out, c0_oe, lvl;
   int fails = 0;
   int comparisons = 0;
   int n_scan = 0, n_dac = 0, n_c0 = 0, base, k;
   always #2 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      if (scan_start === 1'b1) n_scan++;
      if (dac_update === 1'b1) n_dac++;
      if (c0_out === 1'b1) n_c0++;
   end
   dtsr_pin_drv dtsr_pin_drv_inst (.clk_i(clk_i), .pin_o(pin_lvl), .dir_o(dir_lvl));
   dtsr_top dtsr_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .pfi_i(pin_lvl), .pfi_o(echo), .pfi_oe_o(oe), .digital_line_6_i(dir_lvl),
      .buf_done_i(buf_done), .scan_start_o(scan_start), .dac_update_o(dac_update),
      .wave_active_o(wave_active), .counter0_output_o(c0_out), .counter0_output_oe_o(c0_oe));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hf;
      wb_wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 50);
      rd = wb_rdat;
      chk("bus ack", 32'h1, {31'h0, wb_ack});
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   // Counts events of one kind over a span and compares with a window
   task automatic span(input string what, input int n, input int lo, input int hi, ref int cnt);
      base = cnt;
      tick(n);
      chk(what, 32'h1, 32'((cnt - base) >= lo && (cnt - base) <= hi));
   endtask
   task automatic t_regs();
      chk("pin enables at reset", 32'h0, {21'h0, c0_oe, oe});
      wb(1'b1, A_SCAN_DIV, 32'hdead_0003);
      wb(1'b0, A_SCAN_DIV, 32'h0);
      chk("scan divider", 32'h0000_0003, rd);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rd);
      wb(1'b1, A_PIN_OE, 32'hffff_ffff);
      chk("pin enables", 32'h0000_0760, {21'h0, c0_oe, oe});
      $display("test registers done");
   endtask
   task automatic t_scan();
      wb(1'b1, A_ACQ_CFG, 32'h0000_0080);
      span("fast scan rate", 500, 9, 11, n_scan);
      wb(1'b1, A_SCAN_DIV, 32'h0);
      wb(1'b1, A_ACQ_CFG, 32'h0000_4080);
      span("slow scan rate", 6000, 2, 3, n_scan);
      wb(1'b1, A_SCAN_DIV, 32'h3);
      wb(1'b1, A_ACQ_CFG, 32'h0000_2080);
      base = n_scan;
      repeat (8) dtsr_pin_drv_inst.pulse(0, 3);
      chk("external scan clock", 32'h2, 32'(n_scan - base));
      wb(1'b1, A_ACQ_CFG, 32'h0000_00d7);
      tick(60);
      span("level gate low active", 500, 0, 0, n_scan);
      dtsr_pin_drv_inst.set_pin(7, 1'b1);
      tick(60);
      span("level gate released", 500, 9, 11, n_scan);
      dtsr_pin_drv_inst.set_pin(7, 1'b0);
      wb(1'b1, A_ACQ_CFG, 32'h0000_00e7);
      dtsr_pin_drv_inst.pulse(7, 3);
      span("first gate edge", 500, 0, 0, n_scan);
      dtsr_pin_drv_inst.pulse(7, 3);
      span("second gate edge", 500, 8, 11, n_scan);
      wb(1'b1, A_ACQ_CFG, 32'h0);
      $display("test scan gating done");
   endtask
   task automatic t_wave();
      wb(1'b1, A_CMD, 32'h1);
      chk("waveform idle", 32'h0, {31'h0, wave_active});
      wb(1'b1, A_WAVE_CFG, 32'h0100_2302);
      dtsr_pin_drv_inst.set_pin(2, 1'b1);
      for (k = 0; echo[6] !== 1'b1 && k < 20; k++) tick(1);
      for (k = 0; echo[6] === 1'b1 && k < 200; k++) tick(1);
      chk("trigger echo width", 32'(TRIG_PW_CYC), 32'(k));
      chk("waveform running", 32'h1, {31'h0, wave_active});
      dtsr_pin_drv_inst.set_pin(3, 1'b1);
      for (k = 0; dac_update !== 1'b1 && k < 40; k++) tick(1);
      chk("update latency", 32'h1, 32'(k <= DAC_LAT_CYC));
      for (k = 0; echo[5] === 1'b1 && k < 10; k++) tick(1);
      for (k = 0; echo[5] === 1'b0 && k < 200; k++) tick(1);
      chk("update echo width", 32'(UPD_PW_CYC), 32'(k));
      dtsr_pin_drv_inst.set_pin(3, 1'b0);
      wb(1'b1, A_WAVE_CFG, 32'h0300_2302);
      dtsr_pin_drv_inst.set_pin(3, 1'b1);
      span("software gate", 60, 0, 0, n_dac);
      dtsr_pin_drv_inst.set_pin(3, 1'b0);
      wb(1'b1, A_WAVE_CFG, 32'h0000_2302);
      dtsr_pin_drv_inst.set_pin(3, 1'b1);
      span("not posted", 60, 0, 0, n_dac);
      buf_done <= 1'b1;
      tick(1);
      buf_done <= 1'b0;
      tick(3);
      chk("buffer stop", 32'h0, {31'h0, wave_active});
      dtsr_pin_drv_inst.set_pin(2, 1'b0);
      wb(1'b1, A_UI_DIV, 32'h7);
      wb(1'b1, A_WAVE_CFG, 32'h0100_0002);
      span("no update before trigger", 100, 0, 0, n_dac);
      dtsr_pin_drv_inst.set_pin(2, 1'b1);
      span("internal update rate", 500, 4, 5, n_dac);
      wb(1'b1, A_CMD, 32'h1);
      tick(60);
      span("software stop", 200, 0, 0, n_dac);
      $display("test waveform done");
   endtask
   task automatic t_ctr();
      wb(1'b1, A_CTR_LOAD, 32'h2);
      wb(1'b1, A_CTR_CFG, 32'h0004_8124);
      dtsr_pin_drv_inst.set_pin(1, 1'b1);
      dtsr_pin_drv_inst.set_pin(4, 1'b1);
      tick(6);
      chk("gate echo", 32'h3, {30'h0, echo[9:8]});
      base = n_c0;
      dtsr_pin_drv_inst.set_pin(4, 1'b0);
      tick(10);
      repeat (8) dtsr_pin_drv_inst.pulse(4, 4);
      chk("terminal count pulses", 32'h3, 32'(n_c0 - base));
      wb(1'b1, A_CTR_CFG, 32'h0005_8124);
      tick(5);
      lvl = c0_out;
      repeat (3) dtsr_pin_drv_inst.pulse(4, 4);
      chk("toggle on terminal count", {31'h0, ~lvl}, {31'h0, c0_out});
      wb(1'b1, A_CTR_CFG, 32'h0004_c124);
      dtsr_pin_drv_inst.set_pin(1, 1'b0);
      dtsr_pin_drv_inst.pulse(1, 4);
      wb(1'b0, A_CTR_SAVE, 32'h0);
      chk("saved count", 32'h0002_0002, rd);
      $display("test counter done");
   endtask
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      tick(60000);
      fails++;
      report_and_stop();
   end
   initial
   begin
      tick(10);
      rst_i <= 1'b0;
      tick(2);
      chk("update echo idle", 32'h1, {31'h0, echo[5]});
      t_regs();
      t_scan();
      t_wave();
      t_ctr();
      report_and_stop();
   end
endmodule
